// ### hdl/ccp_pkg.sv
package ccp_pkg;
    localparam logic [6:0] SLAVE_ADDR = 7'h54;
    localparam logic [7:0] CMD_T_HOLD = 8'hE3;
    localparam logic [7:0] CMD_T_NOHOLD = 8'hF3;
    localparam logic [7:0] CMD_HT_HOLD = 8'hE5;
    localparam logic [7:0] CMD_HT_NOHOLD = 8'hF5;
    localparam logic [7:0] CMD_CFG_RD = 8'hA7;
    localparam logic [7:0] CMD_CFG_WR = 8'hA6;
    localparam logic [7:0] CMD_STOP_PER = 8'h30;
    localparam logic [7:0] CRC_POLY = 8'h1D;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] TX_BIT_LAST = 4'h7;
    // Bytes still to send after the first one has been loaded
    localparam logic [2:0] TX_LEFT_T = 3'h2;
    localparam logic [2:0] TX_LEFT_HT = 3'h4;
    localparam int WORD_W = 16;
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_CMD, S_DATA, S_HOLD, S_TX, S_IGNORE
    } ccp_state_t;
endpackage

// ### hdl/ccp_cmd_port.sv
// Operation
// - Slave only, 100 and 400 kHz bit rates
// - Answer only address 54 hex
// - Sample on SCL rise, hold SDA while high
// - Address then direction bit, 1 reads
// - Eight bits then response bit, 0 acknowledges
// - After acknowledge, next byte, repeated START or STOP
// - E3/F3 measure temperature, two bytes plus CRC
// - E5/F5 start humidity plus temperature measurement
// - Combined result: humidity, temperature, then CRC
// - A7 reads, A6 writes configuration register
// - Hold style stretches SCL until done
// - No-hold style never stretches SCL
// - Write address wakes, then command byte
// - Hold read: repeated START, stretch, shift out
// - No-hold read NACKed while busy, retried
// - Results MSB first, RES_W bits (14 by default)
// - CRC8 poly 1D, init FF, zero humidity
// - Command 30 stops periodic mode, sleeps
`timescale 1ns/1ps
module ccp_cmd_port #(
    parameter int RES_W = 14
)(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic meas_start,
    output logic meas_humid,
    input wire logic meas_done,
    input wire logic [RES_W-1:0] hum_data,
    input wire logic [RES_W-1:0] temp_data,
    output logic meas_busy,
    output logic cfg_read_cmd,
    output logic cfg_write_cmd,
    output logic periodic_stop,
    output logic asleep
);
    localparam int PAD_W = ccp_pkg::WORD_W - RES_W;

    function automatic logic [7:0] crc8(input logic [31:0] d);
        logic [7:0] c;
        logic fb;
        c = ccp_pkg::CRC_INIT;
        for (int i = 31; i >= 0; i--)
        begin
            fb = c[7] ^ d[i];
            c = {c[6:0], 1'b0};
            if (fb)
                c = c ^ ccp_pkg::CRC_POLY;
        end
        return c;
    endfunction

    logic [2:0] scl_sync_reg, sda_sync_reg;
    logic scl_f_reg, sda_f_reg;
    logic scl_agree, sda_agree, scl_rise, scl_fall, start_det, stop_det;
    ccp_pkg::ccp_state_t state_reg, after_reg, dec_next;
    logic [3:0] bit_cnt_reg;
    logic ack_phase_reg, mack_reg, dec_ack;
    logic [7:0] rx_reg, tx_reg;
    logic [31:0] tx_buf_reg;
    logic [2:0] tx_left_reg;
    logic sda_oe_reg, scl_oe_reg, sda_out_reg, scl_out_reg;
    logic cfg_rd_reg, cfg_wr_reg, stop_per_reg;
    logic meas_start_reg, humid_reg, hold_reg, busy_reg, valid_reg;
    logic asleep_reg;
    logic [39:0] result_word_reg;
    logic byte_done, cmd_take, meas_cmd, cmd_known, consume;
    logic [15:0] hum_w, temp_w;

    assign scl_out = scl_out_reg;
    assign scl_oe = scl_oe_reg;
    assign sda_out = sda_out_reg;
    assign sda_oe = sda_oe_reg;
    assign meas_start = meas_start_reg;
    assign meas_humid = humid_reg;
    assign meas_busy = busy_reg;
    assign cfg_read_cmd = cfg_rd_reg;
    assign cfg_write_cmd = cfg_wr_reg;
    assign periodic_stop = stop_per_reg;
    assign asleep = asleep_reg;
    assign hum_w = {{PAD_W{1'b0}}, hum_data};
    assign temp_w = {{PAD_W{1'b0}}, temp_data};

    // Three-stage pin capture; a level counts once stages two and three agree
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_f_reg <= 1'b1;
            sda_f_reg <= 1'b1;
        end
        else if (ce)
        begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
            if (scl_agree)
                scl_f_reg <= scl_sync_reg[2];
            if (sda_agree)
                sda_f_reg <= sda_sync_reg[2];
        end
    end

    always_comb
    begin
        scl_agree = scl_sync_reg[1] == scl_sync_reg[2];
        sda_agree = sda_sync_reg[1] == sda_sync_reg[2];
        scl_rise = scl_agree && scl_sync_reg[2] && !scl_f_reg;
        scl_fall = scl_agree && !scl_sync_reg[2] && scl_f_reg;
        // SDA moving while SCL is high marks START or STOP
        start_det = sda_agree && !sda_sync_reg[2] && sda_f_reg
            && scl_f_reg && !scl_fall;
        stop_det = sda_agree && sda_sync_reg[2] && !sda_f_reg
            && scl_f_reg && !scl_fall;
    end

    always_comb
    begin
        byte_done = scl_fall && !ack_phase_reg
            && bit_cnt_reg == ccp_pkg::BIT_LAST;
        meas_cmd = rx_reg == ccp_pkg::CMD_T_HOLD
            || rx_reg == ccp_pkg::CMD_T_NOHOLD
            || rx_reg == ccp_pkg::CMD_HT_HOLD
            || rx_reg == ccp_pkg::CMD_HT_NOHOLD;
        cmd_known = meas_cmd || rx_reg == ccp_pkg::CMD_CFG_RD
            || rx_reg == ccp_pkg::CMD_CFG_WR
            || rx_reg == ccp_pkg::CMD_STOP_PER;
        cmd_take = state_reg == ccp_pkg::S_CMD && byte_done;
        consume = state_reg == ccp_pkg::S_TX && scl_fall
            && ack_phase_reg && tx_left_reg == 3'h0;
        dec_ack = 1'b0;
        dec_next = ccp_pkg::S_IGNORE;
        case (state_reg)
            ccp_pkg::S_ADDR:
            begin
                if (rx_reg[7:1] == ccp_pkg::SLAVE_ADDR)
                begin
                    if (!rx_reg[0])
                    begin
                        dec_ack = 1'b1;
                        dec_next = ccp_pkg::S_CMD;
                    end
                    else if (valid_reg)
                    begin
                        dec_ack = 1'b1;
                        dec_next = ccp_pkg::S_TX;
                    end
                    else if (busy_reg && hold_reg)
                    begin
                        dec_ack = 1'b1;
                        dec_next = ccp_pkg::S_HOLD;
                    end
                end
            end
            ccp_pkg::S_CMD:
            begin
                dec_ack = cmd_known;
                dec_next = cmd_known ? ccp_pkg::S_DATA : ccp_pkg::S_IGNORE;
            end
            ccp_pkg::S_DATA:
            begin
                dec_ack = 1'b1;
                dec_next = ccp_pkg::S_DATA;
            end
            default:
            begin
                dec_ack = 1'b0;
                dec_next = ccp_pkg::S_IGNORE;
            end
        endcase
    end

    // Serial link sequencing: bytes in, response bits, bytes out
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= ccp_pkg::S_IDLE;
            after_reg <= ccp_pkg::S_IDLE;
            bit_cnt_reg <= 4'h0;
            ack_phase_reg <= 1'b0;
            mack_reg <= 1'b0;
            rx_reg <= 8'h00;
            tx_reg <= 8'h00;
            tx_buf_reg <= 32'h00000000;
            tx_left_reg <= 3'h0;
            sda_oe_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
            sda_out_reg <= 1'b0;
            scl_out_reg <= 1'b0;
            cfg_rd_reg <= 1'b0;
            cfg_wr_reg <= 1'b0;
            stop_per_reg <= 1'b0;
        end
        else if (ce)
        begin
            cfg_rd_reg <= 1'b0;
            cfg_wr_reg <= 1'b0;
            stop_per_reg <= 1'b0;
            if (stop_det)
            begin
                state_reg <= ccp_pkg::S_IDLE;
                ack_phase_reg <= 1'b0;
                sda_oe_reg <= 1'b0;
                scl_oe_reg <= 1'b0;
            end
            else if (start_det)
            begin
                state_reg <= ccp_pkg::S_ADDR;
                bit_cnt_reg <= 4'h0;
                ack_phase_reg <= 1'b0;
                sda_oe_reg <= 1'b0;
                scl_oe_reg <= 1'b0;
            end
            else
            begin
                case (state_reg)
                    ccp_pkg::S_ADDR, ccp_pkg::S_CMD, ccp_pkg::S_DATA:
                    begin
                        if (scl_rise && !ack_phase_reg)
                        begin
                            rx_reg <= {rx_reg[6:0], sda_f_reg};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        if (byte_done)
                        begin
                            ack_phase_reg <= 1'b1;
                            sda_oe_reg <= dec_ack;
                            after_reg <= dec_next;
                            if (state_reg == ccp_pkg::S_CMD)
                            begin
                                cfg_rd_reg <= rx_reg == ccp_pkg::CMD_CFG_RD;
                                cfg_wr_reg <= rx_reg == ccp_pkg::CMD_CFG_WR;
                                stop_per_reg <=
                                    rx_reg == ccp_pkg::CMD_STOP_PER;
                            end
                        end
                        else if (scl_fall && ack_phase_reg)
                        begin
                            ack_phase_reg <= 1'b0;
                            bit_cnt_reg <= 4'h0;
                            state_reg <= after_reg;
                            sda_oe_reg <= 1'b0;
                            if (after_reg == ccp_pkg::S_TX)
                            begin
                                sda_oe_reg <= !result_word_reg[39];
                                tx_reg <= {result_word_reg[38:32], 1'b0};
                                tx_buf_reg <= result_word_reg[31:0];
                                tx_left_reg <= humid_reg ? ccp_pkg::TX_LEFT_HT
                                    : ccp_pkg::TX_LEFT_T;
                            end
                            if (after_reg == ccp_pkg::S_HOLD)
                                scl_oe_reg <= 1'b1;
                        end
                    end
                    ccp_pkg::S_HOLD:
                    begin
                        if (valid_reg)
                        begin
                            // First bit is on SDA before SCL is let go
                            sda_oe_reg <= !result_word_reg[39];
                            tx_reg <= {result_word_reg[38:32], 1'b0};
                            tx_buf_reg <= result_word_reg[31:0];
                            tx_left_reg <= humid_reg ? ccp_pkg::TX_LEFT_HT
                                : ccp_pkg::TX_LEFT_T;
                            state_reg <= ccp_pkg::S_TX;
                            bit_cnt_reg <= 4'h0;
                        end
                    end
                    ccp_pkg::S_TX:
                    begin
                        // SCL is let go one cycle after the first bit stands
                        if (scl_oe_reg)
                            scl_oe_reg <= 1'b0;
                        if (scl_rise && ack_phase_reg)
                            mack_reg <= sda_f_reg;
                        if (scl_fall && !ack_phase_reg)
                        begin
                            if (bit_cnt_reg == ccp_pkg::TX_BIT_LAST)
                            begin
                                sda_oe_reg <= 1'b0;
                                ack_phase_reg <= 1'b1;
                            end
                            else
                            begin
                                sda_oe_reg <= !tx_reg[7];
                                tx_reg <= {tx_reg[6:0], 1'b0};
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                        else if (scl_fall && ack_phase_reg)
                        begin
                            ack_phase_reg <= 1'b0;
                            bit_cnt_reg <= 4'h0;
                            if (mack_reg || tx_left_reg == 3'h0)
                                state_reg <= ccp_pkg::S_IGNORE;
                            else
                            begin
                                sda_oe_reg <= !tx_buf_reg[31];
                                tx_reg <= {tx_buf_reg[30:24], 1'b0};
                                tx_buf_reg <= {tx_buf_reg[23:0], 8'h00};
                                tx_left_reg <= tx_left_reg - 3'h1;
                            end
                        end
                    end
                    default:
                    begin
                        sda_oe_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Measurement bookkeeping and result assembly
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meas_start_reg <= 1'b0;
            humid_reg <= 1'b0;
            hold_reg <= 1'b0;
            busy_reg <= 1'b0;
            valid_reg <= 1'b0;
            result_word_reg <= 40'h0000000000;
            asleep_reg <= 1'b1;
        end
        else if (ce)
        begin
            meas_start_reg <= 1'b0;
            if (cmd_take && meas_cmd)
            begin
                meas_start_reg <= 1'b1;
                busy_reg <= 1'b1;
                valid_reg <= 1'b0;
                humid_reg <= rx_reg == ccp_pkg::CMD_HT_HOLD
                    || rx_reg == ccp_pkg::CMD_HT_NOHOLD;
                hold_reg <= rx_reg == ccp_pkg::CMD_T_HOLD
                    || rx_reg == ccp_pkg::CMD_HT_HOLD;
            end
            else if (cmd_take && rx_reg == ccp_pkg::CMD_STOP_PER)
                busy_reg <= 1'b0;
            else if (busy_reg && meas_done)
            begin
                busy_reg <= 1'b0;
                valid_reg <= 1'b1;
                if (humid_reg)
                    result_word_reg <= {hum_w, temp_w,
                        crc8({hum_w, temp_w})};
                else
                    result_word_reg <= {temp_w, crc8({16'h0000, temp_w}),
                        16'h0000};
            end
            else if (consume)
                valid_reg <= 1'b0;
            asleep_reg <= state_reg == ccp_pkg::S_IDLE && !busy_reg;
        end
    end

    default clocking cb @(posedge ref_clk iff ce);
    endclocking
    default disable iff (!arst_n);

    sequence s_addr_byte;
        state_reg == ccp_pkg::S_ADDR && byte_done;
    endsequence
    sequence s_cmd_byte;
        cmd_take;
    endsequence

    property p_addr_ack;
        (s_addr_byte ##0 rx_reg == {ccp_pkg::SLAVE_ADDR, 1'b0})
            |=> sda_oe_reg && ack_phase_reg;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("own write address not acknowledged");
    property p_addr_nack;
        (s_addr_byte ##0 rx_reg[7:1] != ccp_pkg::SLAVE_ADDR)
            |=> !sda_oe_reg && after_reg == ccp_pkg::S_IGNORE;
    endproperty
    a_addr_nack: assert property (p_addr_nack)
        else $error("foreign address answered");
    property p_oe_stable;
        (scl_f_reg && $past(scl_f_reg) && !$past(start_det)
            && !$past(stop_det)) |-> $stable(sda_oe_reg);
    endproperty
    a_oe_stable: assert property (p_oe_stable)
        else $error("SDA drive changed while SCL high");
    property p_meas_temp;
        (s_cmd_byte ##0 (rx_reg == ccp_pkg::CMD_T_HOLD
            || rx_reg == ccp_pkg::CMD_T_NOHOLD))
            |=> meas_start_reg && !humid_reg ##1 !meas_start_reg;
    endproperty
    a_meas_temp: assert property (p_meas_temp)
        else $error("temperature command did not start");
    property p_meas_ht;
        (s_cmd_byte ##0 (rx_reg == ccp_pkg::CMD_HT_HOLD
            || rx_reg == ccp_pkg::CMD_HT_NOHOLD))
            |=> meas_start_reg && humid_reg && busy_reg;
    endproperty
    a_meas_ht: assert property (p_meas_ht)
        else $error("combined command did not start");
    property p_cfg_rd;
        (s_cmd_byte ##0 rx_reg == ccp_pkg::CMD_CFG_RD)
            |=> cfg_rd_reg && !cfg_wr_reg ##1 !cfg_rd_reg;
    endproperty
    a_cfg_rd: assert property (p_cfg_rd)
        else $error("register read command not flagged");
    property p_hold;
        state_reg == ccp_pkg::S_HOLD |-> scl_oe_reg;
    endproperty
    a_hold: assert property (p_hold)
        else $error("SCL not stretched while waiting");
    property p_nohold_nack;
        (s_addr_byte ##0 (rx_reg == {ccp_pkg::SLAVE_ADDR, 1'b1}
            && !valid_reg && !(busy_reg && hold_reg))) |=> !sda_oe_reg;
    endproperty
    a_nohold_nack: assert property (p_nohold_nack)
        else $error("read acknowledged with no result");
    property p_msb_first;
        (state_reg == ccp_pkg::S_HOLD && valid_reg && !start_det
            && !stop_det) |=> sda_oe_reg == !result_word_reg[39];
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("first bit is not the result MSB");
    property p_stop_per;
        (s_cmd_byte ##0 rx_reg == ccp_pkg::CMD_STOP_PER)
            |=> stop_per_reg && !busy_reg;
    endproperty
    a_stop_per: assert property (p_stop_per)
        else $error("periodic stop command ignored");
    property p_sleep;
        (stop_det && !busy_reg) |=> state_reg == ccp_pkg::S_IDLE
            ##1 asleep_reg;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("no sleep after STOP");
    property p_consume;
        consume |=> !valid_reg;
    endproperty
    a_consume: assert property (p_consume)
        else $error("result still valid after last byte");
endmodule

// ### tb/ccp_i2c_master.sv
`timescale 1ns/1ps
module ccp_i2c_master (
    input wire logic scl_w,
    input wire logic sda_w,
    output logic scl_low,
    output logic sda_low
);
    // Quarter bit of a 125 ns period, well above the hold-style floor
    localparam realtime Q = 31.25;
    logic [7:0] rx_byte;
    event rx_ev;
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // Releases SCL and waits, bounded, while the slave stretches it
    task automatic scl_high();
        int n;
        n = 0;
        scl_low = 1'b0;
        while (scl_w !== 1'b1 && n < 100000)
        begin
            #1;
            n++;
        end
        #(2 * Q);
    endtask
    // SDA moves only in the low phase; sampled at the end of the high
    task automatic clk_bit(input logic b, output logic s);
        #Q;
        sda_low = ~b;
        #Q;
        scl_high();
        s = sda_w;
        scl_low = 1'b1;
    endtask
    task automatic start();
        #Q;
        sda_low = 1'b0;
        #Q;
        scl_high();
        sda_low = 1'b1;
        #(2 * Q);
        scl_low = 1'b1;
    endtask
    task automatic stop();
        #Q;
        sda_low = 1'b1;
        #Q;
        scl_high();
        sda_low = 1'b0;
        #(4 * Q);
    endtask
    task automatic put_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(b[i], s);
        clk_bit(1'b1, s);
        rx_byte = {7'h00, s};
        ->rx_ev;
    endtask
    // The last byte of a read is answered with not-acknowledge
    task automatic get_byte(input logic last);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            clk_bit(1'b1, s);
            rx_byte[i] = s;
        end
        clk_bit(last, s);
        ->rx_ev;
    endtask
endmodule

// ### tb/climate_sensor_i2c_cmd_port_bench.sv
`timescale 1ns/1ps
module climate_sensor_i2c_cmd_port_bench;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic meas_done = 1'b0;
    logic [13:0] hum_data = 14'h0000;
    logic [13:0] temp_data = 14'h0000;
    logic scl_out, scl_oe, sda_out, sda_oe, meas_start, meas_humid;
    logic meas_busy, cfg_read_cmd, cfg_write_cmd, periodic_stop, asleep;
    logic scl_low, sda_low;
    // Open-drain wires with pull-ups
    wire scl_w = !(scl_low || (scl_oe && !scl_out));
    wire sda_w = !(sda_low || (sda_oe && !sda_out));
    int errors = 0;
    int n_checks = 0;
    int seed = 93731;
    int dly = 0;
    int cnt = 0;
    int n_str = 0;
    int pc [4] = '{0, 0, 0, 0};
    logic [7:0] exp_q [$];

    always #5 ref_clk = ~ref_clk;

    ccp_cmd_port #(.RES_W(14)) DUT (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .ce(1'b1),
        .scl_in(scl_w),
        .scl_out(scl_out),
        .scl_oe(scl_oe),
        .sda_in(sda_w),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .meas_start(meas_start),
        .meas_humid(meas_humid),
        .meas_done(meas_done),
        .hum_data(hum_data),
        .temp_data(temp_data),
        .meas_busy(meas_busy),
        .cfg_read_cmd(cfg_read_cmd),
        .cfg_write_cmd(cfg_write_cmd),
        .periodic_stop(periodic_stop),
        .asleep(asleep)
    );
    ccp_i2c_master m (.scl_w(scl_w), .sda_w(sda_w),
        .scl_low(scl_low), .sda_low(sda_low));

    always @(posedge ref_clk)
    begin
        if (meas_start === 1'b1) pc[0]++;
        if (cfg_read_cmd === 1'b1) pc[1]++;
        if (cfg_write_cmd === 1'b1) pc[2]++;
        if (periodic_stop === 1'b1) pc[3]++;
        if (scl_oe === 1'b1) n_str++;
    end
    // Sensing core stand-in: done pulse dly cycles after each start
    always @(negedge ref_clk)
    begin
        meas_done <= (cnt == 1);
        cnt <= (meas_start === 1'b1) ? dly : (cnt > 0 ? cnt - 1 : 0);
    end

    task automatic check(input logic [15:0] seen, exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    always @(m.rx_ev)
    begin
        if (exp_q.size() > 0)
            check(m.rx_byte, exp_q.pop_front(), "link");
        else
            check({8'h01, m.rx_byte}, 16'h0000, "spare link byte");
    end
    task automatic put(input logic [7:0] b, input logic nack);
        exp_q.push_back({7'h00, nack});
        m.put_byte(b);
    endtask
    task automatic get(input logic [7:0] b, input logic last);
        exp_q.push_back(b);
        m.get_byte(last);
    endtask
    function automatic logic [7:0] crc8(input logic [31:0] d);
        logic [7:0] c;
        c = ccp_pkg::CRC_INIT;
        for (int i = 31; i >= 0; i--)
            c = (c[7] ^ d[i]) ? ((c << 1) ^ ccp_pkg::CRC_POLY) : (c << 1);
        return c;
    endfunction

    task automatic meas(input logic [7:0] cmd, input int d);
        logic hum;
        logic hold;
        logic [31:0] w;
        int n0;
        hum = cmd == ccp_pkg::CMD_HT_HOLD || cmd == ccp_pkg::CMD_HT_NOHOLD;
        hold = cmd == ccp_pkg::CMD_T_HOLD || cmd == ccp_pkg::CMD_HT_HOLD;
        w = $random(seed);
        @(negedge ref_clk);
        hum_data <= w[29:16];
        temp_data <= w[13:0];
        dly = d;
        w = {hum ? {2'b00, w[29:16]} : 16'h0000, 2'b00, w[13:0]};
        n0 = pc[0];
        n_str = 0;
        m.start();
        put({ccp_pkg::SLAVE_ADDR, 1'b0}, 1'b0);
        put(cmd, 1'b0);
        check(16'(pc[0] - n0), 16'h0001, "meas_start");
        check({15'h0000, meas_humid}, {15'h0000, hum}, "humid");
        if (!hold)
        begin
            m.start();
            put({ccp_pkg::SLAVE_ADDR, 1'b1}, 1'b1);
            m.stop();
            for (int i = 0; i < 5000 && meas_busy !== 1'b0; i++)
                @(negedge ref_clk);
        end
        m.start();
        put({ccp_pkg::SLAVE_ADDR, 1'b1}, 1'b0);
        if (hum) get(w[31:24], 1'b0);
        if (hum) get(w[23:16], 1'b0);
        get(w[15:8], 1'b0);
        get(w[7:0], 1'b0);
        get(crc8(w), 1'b1);
        m.stop();
        check(16'(n_str > 0), 16'(hold), "stretch");
        check({15'h0000, asleep}, 16'h0001, "asleep");
        $display("measurement %h done", cmd);
    endtask
    task automatic cmd_only(input logic [7:0] cmd, input logic nack, int k);
        int n0;
        n0 = pc[k];
        m.start();
        put({ccp_pkg::SLAVE_ADDR, 1'b0}, 1'b0);
        put(cmd, nack);
        put(8'($random(seed)), nack);
        m.stop();
        check(16'(pc[k] - n0), 16'(!nack), "pulse");
        $display("command %h done", cmd);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        logic [6:0] a;
        int n0;
        repeat (6) @(negedge ref_clk);
        check({11'h000, meas_start, meas_busy, scl_oe, sda_oe, asleep},
            16'h0001, "reset");
        arst_n <= 1'b1;
        repeat (6) @(negedge ref_clk);
        meas(ccp_pkg::CMD_T_HOLD, 300);
        meas(ccp_pkg::CMD_HT_HOLD, 300);
        meas(ccp_pkg::CMD_T_NOHOLD, 400);
        meas(ccp_pkg::CMD_HT_NOHOLD, 400);
        cmd_only(ccp_pkg::CMD_CFG_RD, 1'b0, 1);
        cmd_only(ccp_pkg::CMD_CFG_WR, 1'b0, 2);
        cmd_only(ccp_pkg::CMD_STOP_PER, 1'b0, 3);
        cmd_only(8'hD7, 1'b1, 0);
        for (int k = 0; k < 3; k++)
        begin
            a = 7'($random(seed));
            if (a == ccp_pkg::SLAVE_ADDR) a = a ^ 7'h01;
            n0 = pc[0];
            m.start();
            put({a, k[0]}, 1'b1);
            put(ccp_pkg::CMD_T_HOLD, 1'b1);
            m.stop();
            check(16'(pc[0] - n0), 16'h0000, "foreign");
        end
        $display("address tests done");
        test_done();
    end
    initial
    begin
        #300000;
        errors++;
        $display("ERROR watchdog expected finish seen timeout");
        test_done();
    end
endmodule
